// >>> bench/nfsb_assertions.sv
`timescale 1ns/1ps
module nfsb_assertions (
	// clock and reset
	input wire logic       core_clk,
	input wire logic       reset_n,
	// pins
	input wire logic       cs_n,
	input wire logic       wp_n,
	input wire logic       miso_oe,
	// engine
	input wire logic       read_done,
	input wire logic [3:0] ecc_flip_cnt,
	input wire logic       ecc_uncorrectable,
	input wire logic       prog_done,
	input wire logic       erase_done,
	input wire logic       op_fail,
	input wire logic       array_cmd_valid,
	input wire logic [7:0] array_cmd,
	// settings and status
	input wire logic       lock_field_write_guard,
	input wire logic [2:0] lock_range_sel,
	input wire logic       ecc_en,
	input wire logic       otp_protect_arm,
	input wire logic       write_latch,
	input wire logic       program_failed,
	input wire logic       erase_failed,
	input wire logic [1:0] ecc_result
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	// five cycles cover the two-stage pin synchroniser
	AST_GUARD_FREEZE: assert property (
		(!wp_n && lock_field_write_guard)[*5] |=> $stable(lock_range_sel) && lock_field_write_guard)
		else $error("lock fields changed while guarded");
	AST_ECC_CLEAN: assert property (
		read_done && ecc_en && !ecc_uncorrectable && ecc_flip_cnt == 4'h0 |=> ecc_result == 2'h0)
		else $error("clean read not reported as clean");
	AST_ECC_CORR: assert property (
		read_done && ecc_en && !ecc_uncorrectable && ecc_flip_cnt != 4'h0 |=> ecc_result[0])
		else $error("corrected read not reported as corrected");
	AST_ECC_UNCORR: assert property (
		read_done && ecc_en && ecc_uncorrectable |=> ecc_result == 2'h2)
		else $error("uncorrectable read misreported");
	AST_PROG_FAIL: assert property (
		prog_done |=> program_failed == $past(op_fail))
		else $error("program result not latched");
	AST_ERASE_FAIL: assert property (
		erase_done |=> erase_failed == $past(op_fail))
		else $error("erase result not latched");
	AST_FAIL_HOLD: assert property (
		(!prog_done && !erase_done && !array_cmd_valid) ##1 !array_cmd_valid
		|-> $stable(program_failed) && $stable(erase_failed))
		else $error("fail bits moved without a command");
	AST_LATCH_NEEDED: assert property (
		array_cmd_valid && array_cmd != 8'h13 |-> write_latch)
		else $error("write command launched without latch");
	AST_PROTECT_ARMED: assert property (
		array_cmd_valid && array_cmd == 8'h2A |-> otp_protect_arm)
		else $error("protect launched while not armed");
	AST_OE_IDLE: assert property (
		cs_n [*8] |-> !miso_oe)
		else $error("output driven while deselected");
endmodule // nfsb_assertions

bind nfsb_bank nfsb_assertions i_nfsb_assertions (
	.core_clk(core_clk), .reset_n(reset_n), .cs_n(cs_n), .wp_n(wp_n), .miso_oe(miso_oe),
	.read_done(read_done), .ecc_flip_cnt(ecc_flip_cnt), .ecc_uncorrectable(ecc_uncorrectable),
	.prog_done(prog_done), .erase_done(erase_done), .op_fail(op_fail),
	.array_cmd_valid(array_cmd_valid), .array_cmd(array_cmd),
	.lock_field_write_guard(lock_field_write_guard), .lock_range_sel(lock_range_sel),
	.ecc_en(ecc_en), .otp_protect_arm(otp_protect_arm), .write_latch(write_latch),
	.program_failed(program_failed), .erase_failed(erase_failed), .ecc_result(ecc_result));

// >>> bench/nfsb_host.sv
`timescale 1ns/1ps
module nfsb_host (
	// timing reference
	input wire logic core_clk,
	// serial pins
	output logic     sclk,
	output logic     cs_n,
	output logic     mosi,
	input wire logic miso
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end

	// mode 0 frame: ntx bytes out msb first, then nrx bytes captured late in each bit
	task automatic frame(input logic [31:0] tx, input int ntx, input int nrx,
		output logic [23:0] rx);
		int i;
		rx = 24'h000000;
		@(posedge core_clk);
		#2 cs_n = 1'b0;
		for (i = 0; i < 8 * (ntx + nrx); i++) begin
			mosi = (i < 8 * ntx) ? tx[8 * ntx - 1 - i] : ~mosi;
			#100 sclk = 1'b1;
			#90 if (i >= 8 * ntx) rx = {rx[22:0], miso};
			#10 sclk = 1'b0;
		end
		// released data line flips so a stale level is never mistaken for data
		#100 cs_n = 1'b1;
		mosi = ~mosi;
		#200;
	endtask
endmodule // nfsb_host

// >>> bench/tb.sv
`timescale 1ns/1ps
`include "nfsb_consts.vh"
module tb;
	logic        core_clk, reset_n, wp_n, hold_n, array_busy, read_done;
	logic        ecc_uncorrectable, prog_done, erase_done, op_fail;
	logic [3:0]  ecc_flip_cnt;
	wire         sclk, cs_n, mosi, miso, miso_oe, array_cmd_valid, array_abort;
	wire [7:0]   array_cmd;
	wire [23:0]  array_row;
	wire [10:0]  lock_floor;
	wire         lock_field_write_guard, id_page_read_en, ecc_en, otp_protect_arm;
	wire         fast_page_read_en, hold_disable, write_latch, program_failed, erase_failed;
	wire [2:0]   lock_range_sel;
	wire [1:0]   ecc_result;
	logic [23:0] rx;
	int          mismatches, n_compared, n_cmd, n_abort, c;
	// first locked block for each range code on a 1024-block array
	int          floor_exp [8] = '{1024, 1008, 992, 960, 896, 768, 512, 0};

	nfsb_bank i_nfsb_bank (.core_clk(core_clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n),
		.mosi(mosi), .wp_n(wp_n), .hold_n(hold_n), .miso(miso), .miso_oe(miso_oe),
		.array_busy(array_busy), .read_done(read_done), .ecc_flip_cnt(ecc_flip_cnt),
		.ecc_uncorrectable(ecc_uncorrectable), .prog_done(prog_done), .erase_done(erase_done),
		.op_fail(op_fail), .array_cmd_valid(array_cmd_valid), .array_cmd(array_cmd),
		.array_row(array_row), .array_abort(array_abort),
		.lock_field_write_guard(lock_field_write_guard),
		.lock_range_sel(lock_range_sel), .lock_floor(lock_floor), .id_page_read_en(id_page_read_en),
		.ecc_en(ecc_en), .otp_protect_arm(otp_protect_arm), .fast_page_read_en(fast_page_read_en),
		.hold_disable(hold_disable), .write_latch(write_latch), .program_failed(program_failed),
		.erase_failed(erase_failed), .ecc_result(ecc_result));
	nfsb_host i_nfsb_host (.core_clk(core_clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		if (array_cmd_valid === 1'b1) n_cmd++;
		if (array_abort === 1'b1) n_abort++;
	end

	task report_and_stop;
		$display("mismatches %0d compared %0d", mismatches, n_compared);
		if (mismatches == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task setf(input logic [7:0] a, input logic [7:0] d);
		i_nfsb_host.frame({`NFSB_CMD_SET, a, d}, 3, 0, rx);
	endtask
	task getf(input logic [7:0] a, input int n);
		i_nfsb_host.frame({`NFSB_CMD_GET, a}, 2, n, rx);
	endtask
	task cmd(input logic [7:0] op);
		i_nfsb_host.frame({24'h000000, op}, 1, 0, rx);
	endtask
	task arr(input logic [7:0] op);
		i_nfsb_host.frame({op, 24'h000140}, 4, 0, rx);
	endtask
	// one-cycle engine pulse; sel is {read, program, erase}
	task eng(input logic [2:0] sel, input logic f, input logic [3:0] cnt);
		@(posedge core_clk);
		#2 {read_done, prog_done, erase_done} = sel;
		op_fail = f;
		ecc_uncorrectable = f;
		ecc_flip_cnt = cnt;
		@(posedge core_clk);
		#2 {read_done, prog_done, erase_done} = 3'b000;
		repeat (2) @(posedge core_clk);
	endtask

	initial begin
		repeat (100000) @(posedge core_clk);
		mismatches++;
		report_and_stop;
	end

	initial begin
		{reset_n, wp_n, hold_n, array_busy, read_done} = 5'b01100;
		{ecc_uncorrectable, prog_done, erase_done, op_fail} = 4'h0;
		ecc_flip_cnt = 4'h0;
		repeat (8) @(posedge core_clk);
		#2 reset_n = 1'b1;
		repeat (4) @(posedge core_clk);
		check(lock_range_sel, 3'h7);
		check(lock_field_write_guard, 1'b0);
		check({id_page_read_en, ecc_en, otp_protect_arm, fast_page_read_en, hold_disable}, 5'h0A);
		getf(8'hA0, 1); check(rx[7:0], 8'h38);
		getf(8'hB0, 1); check(rx[7:0], 8'h12);
		getf(8'hC0, 2); check(rx[15:0], 16'h0000);
		setf(8'hB0, 8'hFF); getf(8'hB0, 1); check(rx[7:0], 8'h57);
		check({id_page_read_en, otp_protect_arm, hold_disable}, 3'h7);
		@(posedge core_clk);
		#2 hold_n = 1'b0;
		getf(8'hB0, 1); check(rx[7:0], 8'h57);
		@(posedge core_clk);
		#2 hold_n = 1'b1;
		setf(8'hC0, 8'hFF); getf(8'hC0, 1); check(rx[7:0], 8'h00);
		cmd(8'h06); check(write_latch, 1'b1);
		cmd(8'hFF); check(n_abort, 1);
		getf(8'hB0, 1); check(rx[7:0], 8'h57);
		setf(8'hB0, 8'h12);
		// hold active again: a paused frame must not reach the latch
		@(posedge core_clk);
		#2 hold_n = 1'b0;
		cmd(8'h04); check(write_latch, 1'b1);
		@(posedge core_clk);
		#2 hold_n = 1'b1;
		for (c = 0; c < 8; c++) begin
			setf(8'hA0, c << 3); getf(8'hA0, 1); check(rx[7:0], c << 3);
			check(lock_floor, floor_exp[c]);
		end
		setf(8'hA0, 8'h90);
		@(posedge core_clk);
		#2 wp_n = 1'b0;
		setf(8'hA0, 8'h00); getf(8'hA0, 1); check(rx[7:0], 8'h90);
		@(posedge core_clk);
		#2 wp_n = 1'b1;
		setf(8'hA0, 8'h00); getf(8'hA0, 1); check(rx[7:0], 8'h00);
		setf(8'h10, 8'h30);
		eng(3'b100, 1'b0, 4'h0); check(ecc_result, 2'h0);
		eng(3'b100, 1'b0, 4'h2); check(ecc_result, 2'h1);
		eng(3'b100, 1'b0, 4'h3); check(ecc_result, 2'h3);
		eng(3'b100, 1'b1, 4'h0); getf(8'hC0, 1); check(rx[7:0], 8'h22);
		arr(8'h10); check(n_cmd, 1);
		check(array_row, 24'h000140);
		eng(3'b010, 1'b1, 4'h0); check(program_failed, 1'b1);
		fork
			getf(8'hC0, 3);
			begin
				repeat (160) @(posedge core_clk);
				#2 array_busy = 1'b1;
			end
		join
		check(rx, 24'h2A2B2B);
		array_busy = 1'b0;
		arr(8'hD8); check(program_failed, 1'b0);
		eng(3'b001, 1'b1, 4'h0); check(erase_failed, 1'b1);
		cmd(8'h06); check(erase_failed, 1'b1);
		cmd(8'h04); arr(8'h10); check(n_cmd, 2);
		cmd(8'h06); arr(8'h2A); check(n_cmd, 2);
		setf(8'hB0, 8'h16); cmd(8'h06); arr(8'h2A); check(n_cmd, 3);
		check(array_cmd, 8'h2A);
		report_and_stop;
	end
endmodule // tb

// >>> design/nfsb_bank.v
`timescale 1ns/1ps
`include "nfsb_consts.vh"
module nfsb_bank #(
	parameter BLK_LOG2 = 10
) (
	// clock and reset
	input  wire              core_clk,
	input  wire              reset_n,
	// serial pins
	input  wire              sclk,
	input  wire              cs_n,
	input  wire              mosi,
	input  wire              wp_n,
	input  wire              hold_n,
	output wire              miso,
	output reg               miso_oe,
	// array engine status
	input  wire              array_busy,
	input  wire              read_done,
	input  wire [3:0]        ecc_flip_cnt,
	input  wire              ecc_uncorrectable,
	input  wire              prog_done,
	input  wire              erase_done,
	input  wire              op_fail,
	// array engine commands
	output reg               array_cmd_valid,
	output reg  [7:0]        array_cmd,
	output reg  [23:0]       array_row,
	output reg               array_abort,
	// settings
	output reg               lock_field_write_guard,
	output reg  [2:0]        lock_range_sel,
	output reg  [BLK_LOG2:0] lock_floor,
	output reg               id_page_read_en,
	output reg               ecc_en,
	output reg               otp_protect_arm,
	output reg               fast_page_read_en,
	output reg               hold_disable,
	// status
	output reg               write_latch,
	output reg               program_failed,
	output reg               erase_failed,
	output reg  [1:0]        ecc_result
);
	localparam [2:0] F_CMD     = 3'h0;
	localparam [2:0] F_FADDR   = 3'h1;
	localparam [2:0] F_SETDATA = 3'h2;
	localparam [2:0] F_GET     = 3'h3;
	localparam [2:0] F_ROW     = 3'h4;
	localparam [2:0] F_SKIP    = 3'h5;

	localparam [BLK_LOG2:0] NBLK = {1'b1, {BLK_LOG2{1'b0}}};
	localparam [7:0]        LOCK_RST = `NFSB_LOCK_RST;
	localparam [7:0]        MODE_RST = `NFSB_MODE_RST;

	wire [4:0] pin_s;
	wire       s_sclk;
	wire       s_cs_n;
	wire       s_mosi;
	wire       s_wp_n;
	wire       s_hold_n;

	reg        sclk_d;
	reg        cs_d;
	reg  [2:0] frame;
	reg  [7:0] rx;
	reg  [2:0] bit_cnt;
	reg  [7:0] fcmd;
	reg  [7:0] faddr;
	reg  [1:0] row_cnt;
	reg        exec_pend;
	reg  [3:0] ecc_threshold;
	reg  [7:0] feat_byte;
	reg  [1:0] next_ecc;

	wire       held;
	wire       rise;
	wire       fall;
	wire       cs_rise;
	wire [7:0] rx_next;
	wire       byte_done;
	wire       exec_now;
	wire       guard_locked;
	wire [7:0] lock_byte;
	wire [7:0] mode_byte;
	wire [7:0] status_byte;
	wire [7:0] thr_byte;

	nfsb_sync #(
		.W   (5),
		.RST (`NFSB_PIN_IDLE)
	) u_pins (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.d        ({sclk, cs_n, mosi, wp_n, hold_n}),
		.q        (pin_s)
	);

	assign s_sclk   = pin_s[4];
	assign s_cs_n   = pin_s[3];
	assign s_mosi   = pin_s[2];
	assign s_wp_n   = pin_s[1];
	assign s_hold_n = pin_s[0];

	// a paused host freezes the clock edges and drops miso_oe,
	// unless hold_disable is set
	assign held      = ~s_hold_n & ~hold_disable;
	assign rise      = s_sclk & ~sclk_d & ~s_cs_n & ~held;
	assign fall      = ~s_sclk & sclk_d & ~s_cs_n & ~held;
	assign cs_rise   = s_cs_n & ~cs_d;
	assign rx_next   = {rx[6:0], s_mosi};
	assign byte_done = rise & (bit_cnt == 3'h7);
	assign exec_now  = cs_rise & exec_pend;

	assign guard_locked = lock_field_write_guard & ~s_wp_n;

	// reserved positions are tied low in every byte
	assign lock_byte   = {lock_field_write_guard, 1'b0, lock_range_sel, 3'h0};
	assign mode_byte   = {1'b0, id_page_read_en, 1'b0, ecc_en, 1'b0,
	                      otp_protect_arm, fast_page_read_en, hold_disable};
	assign status_byte = {2'h0, ecc_result, program_failed, erase_failed,
	                      write_latch, array_busy};
	assign thr_byte    = {ecc_threshold, 4'h0};

	// status is built from live state, never latched at the command
	always @* begin
		case (faddr)
		`NFSB_ADDR_LOCK: feat_byte = lock_byte;
		`NFSB_ADDR_MODE: feat_byte = mode_byte;
		`NFSB_ADDR_STAT: feat_byte = status_byte;
		`NFSB_ADDR_THR:  feat_byte = thr_byte;
		default:         feat_byte = 8'h00;
		endcase
	end

	nfsb_shift u_tx (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.clear    (s_cs_n),
		.step     (fall & (frame == F_GET)),
		.din      (feat_byte),
		.q        (miso)
	);

	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			sclk_d  <= 1'b0;
			cs_d    <= 1'b1;
			miso_oe <= 1'b0;
		end else begin
			sclk_d  <= s_sclk;
			cs_d    <= s_cs_n;
			miso_oe <= ~s_cs_n & (frame == F_GET) & ~held;
		end
	end

	// frame decoder; reset_n is the power-on reset, reset commands
	// only abort the array and leave every feature untouched
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			frame                  <= F_CMD;
			rx                     <= 8'h00;
			bit_cnt                <= 3'h0;
			fcmd                   <= 8'h00;
			faddr                  <= 8'h00;
			row_cnt                <= 2'h0;
			exec_pend              <= 1'b0;
			array_cmd_valid        <= 1'b0;
			array_cmd              <= 8'h00;
			array_row              <= 24'h000000;
			array_abort            <= 1'b0;
			write_latch            <= 1'b0;
			lock_field_write_guard <= LOCK_RST[`NFSB_LOCK_GUARD];
			lock_range_sel         <= LOCK_RST[`NFSB_LOCK_HI:`NFSB_LOCK_LO];
			id_page_read_en        <= MODE_RST[`NFSB_MODE_IDR];
			ecc_en                 <= MODE_RST[`NFSB_MODE_ECC];
			otp_protect_arm        <= MODE_RST[`NFSB_MODE_PRT];
			fast_page_read_en      <= MODE_RST[`NFSB_MODE_HSE];
			hold_disable           <= MODE_RST[`NFSB_MODE_HOLDD];
			ecc_threshold          <= `NFSB_THR_RST;
		end else begin
			array_cmd_valid <= 1'b0;
			array_abort     <= 1'b0;
			if (s_cs_n) begin
				frame     <= F_CMD;
				bit_cnt   <= 3'h0;
				exec_pend <= 1'b0;
				if (exec_now) begin
					array_cmd_valid <= 1'b1;
					array_cmd       <= fcmd;
				end
			end else if (rise) begin
				rx      <= rx_next;
				bit_cnt <= bit_cnt + 3'h1;
				if (byte_done) begin
					case (frame)
					F_CMD: begin
						fcmd    <= rx_next;
						row_cnt <= 2'h0;
						frame   <= F_SKIP;
						case (rx_next)
						`NFSB_CMD_SET, `NFSB_CMD_GET: begin
							frame <= F_FADDR;
						end
						`NFSB_CMD_WREN: begin
							write_latch <= 1'b1;
						end
						`NFSB_CMD_WRDI: begin
							write_latch <= 1'b0;
						end
						`NFSB_CMD_RST0, `NFSB_CMD_RST1: begin
							array_abort <= 1'b1;
						end
						`NFSB_CMD_PROG, `NFSB_CMD_ERASE: begin
							if (write_latch)
								frame <= F_ROW;
						end
						`NFSB_CMD_PROT: begin
							if (write_latch && otp_protect_arm)
								frame <= F_ROW;
						end
						`NFSB_CMD_READ: begin
							frame <= F_ROW;
						end
						default: begin
							frame <= F_SKIP;
						end
						endcase
					end
					F_FADDR: begin
						faddr <= rx_next;
						if (fcmd == `NFSB_CMD_GET)
							frame <= F_GET;
						else
							frame <= F_SETDATA;
					end
					F_SETDATA: begin
						frame <= F_SKIP;
						// status byte and unknown addresses take no write
						case (faddr)
						`NFSB_ADDR_LOCK: begin
							if (!guard_locked) begin
								lock_field_write_guard <= rx_next[`NFSB_LOCK_GUARD];
								lock_range_sel <= rx_next[`NFSB_LOCK_HI:`NFSB_LOCK_LO];
							end
						end
						`NFSB_ADDR_MODE: begin
							id_page_read_en   <= rx_next[`NFSB_MODE_IDR];
							ecc_en            <= rx_next[`NFSB_MODE_ECC];
							otp_protect_arm   <= rx_next[`NFSB_MODE_PRT];
							fast_page_read_en <= rx_next[`NFSB_MODE_HSE];
							hold_disable      <= rx_next[`NFSB_MODE_HOLDD];
						end
						`NFSB_ADDR_THR: begin
							ecc_threshold <= rx_next[`NFSB_THR_HI:`NFSB_THR_LO];
						end
						default: begin
							frame <= F_SKIP;
						end
						endcase
					end
					F_ROW: begin
						array_row <= {array_row[15:0], rx_next};
						row_cnt   <= row_cnt + 2'h1;
						if (row_cnt == `NFSB_ROW_BYTES) begin
							exec_pend <= 1'b1;
							frame     <= F_SKIP;
						end
					end
					default: begin
						frame <= frame;
					end
					endcase
				end
			end
		end
	end

	// lowest locked block; everything at or above it is locked
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			lock_floor <= {(BLK_LOG2+1){1'b0}};
		end else begin
			case (lock_range_sel)
			`NFSB_RANGE_NONE: lock_floor <= NBLK;
			`NFSB_RANGE_ALL:  lock_floor <= {(BLK_LOG2+1){1'b0}};
			default:          lock_floor <= NBLK - (NBLK >> (3'h7 - lock_range_sel));
			endcase
		end
	end

	always @* begin
		if (!ecc_en)
			next_ecc = `NFSB_ECC_NONE;
		else if (ecc_uncorrectable)
			next_ecc = `NFSB_ECC_UNCORR;
		else if (ecc_flip_cnt == 4'h0)
			next_ecc = `NFSB_ECC_NONE;
		else if (ecc_flip_cnt < ecc_threshold)
			next_ecc = `NFSB_ECC_CORR;
		else
			next_ecc = `NFSB_ECC_CORR_HI;
	end

	// a result arriving with the clear wins, so no failure is lost
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			program_failed <= 1'b0;
			erase_failed   <= 1'b0;
			ecc_result     <= `NFSB_ECC_NONE;
		end else begin
			if (prog_done)
				program_failed <= op_fail;
			else if (exec_now)
				program_failed <= 1'b0;
			if (erase_done)
				erase_failed <= op_fail;
			else if (exec_now)
				erase_failed <= 1'b0;
			if (read_done)
				ecc_result <= next_ecc;
		end
	end
endmodule // nfsb_bank

// >>> design/nfsb_consts.vh
// Notes on behaviour
// - guard bit plus low wp freezes lock fields
// - lock range bits 5:3, default all locked
// - codes 1..6 lock upper 1/64 to 1/2
// - mode bit 6 selects id page read
// - mode bit 4 enables ecc, default on
// - protect execute accepted only while armed
// - mode bit 1 fast page read, default on
// - mode bit 0 set ignores hold pin
// - ecc result 00 when no flips
// - corrected: 01 below threshold, 11 otherwise
// - ecc result 10 when uncorrectable
// - threshold comes from address 10h bits 7:4
// - status bit 3 program or protect failed
// - status bit 2 erase failed
// - write latch changed only by 06h/04h
// - status bit 0 busy while operating
// - get feature repeats selected byte continuously
// - repeated status bytes show live state
// - fail bits hold until next accepted array command
// - reserved bits always read zero
// - features survive reset commands, not power
// - no latch: ignore program, protect, erase
// - 1Fh writes, 0Fh reads, then address
`ifndef NFSB_CONSTS_VH
`define NFSB_CONSTS_VH

`define NFSB_ADDR_LOCK   8'hA0
`define NFSB_ADDR_MODE   8'hB0
`define NFSB_ADDR_STAT   8'hC0
`define NFSB_ADDR_THR    8'h10

`define NFSB_LOCK_GUARD  7
`define NFSB_LOCK_HI     5
`define NFSB_LOCK_LO     3
`define NFSB_MODE_IDR    6
`define NFSB_MODE_ECC    4
`define NFSB_MODE_PRT    2
`define NFSB_MODE_HSE    1
`define NFSB_MODE_HOLDD  0
`define NFSB_THR_HI      7
`define NFSB_THR_LO      4

`define NFSB_LOCK_RST    8'h38
`define NFSB_MODE_RST    8'h12
`define NFSB_THR_RST     4'h1
`define NFSB_RANGE_NONE  3'h0
`define NFSB_RANGE_ALL   3'h7

`define NFSB_CMD_SET     8'h1F
`define NFSB_CMD_GET     8'h0F
`define NFSB_CMD_WREN    8'h06
`define NFSB_CMD_WRDI    8'h04
`define NFSB_CMD_RST0    8'hFF
`define NFSB_CMD_RST1    8'hFE
`define NFSB_CMD_PROG    8'h10
`define NFSB_CMD_ERASE   8'hD8
`define NFSB_CMD_PROT    8'h2A
`define NFSB_CMD_READ    8'h13

`define NFSB_ECC_NONE    2'h0
`define NFSB_ECC_CORR    2'h1
`define NFSB_ECC_UNCORR  2'h2
`define NFSB_ECC_CORR_HI 2'h3

`define NFSB_ROW_BYTES   2'h2
`define NFSB_PIN_IDLE    5'h0B

`endif

// >>> design/nfsb_shift.v
`timescale 1ns/1ps
module nfsb_shift (
	// clock and reset
	input  wire       core_clk,
	input  wire       reset_n,
	// control
	input  wire       clear,
	input  wire       step,
	input  wire [7:0] din,
	// serial out
	output reg        q
);
	reg [2:0] cnt;
	reg [7:0] sh;

	// din is sampled afresh at the first bit of every byte, so a
	// repeated byte always carries the current value
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt <= 3'h0;
			sh  <= 8'h00;
			q   <= 1'b0;
		end else if (clear) begin
			cnt <= 3'h0;
		end else if (step) begin
			if (cnt == 3'h0) begin
				q  <= din[7];
				sh <= {din[6:0], 1'b0};
			end else begin
				q  <= sh[7];
				sh <= {sh[6:0], 1'b0};
			end
			cnt <= cnt - 3'h1;
		end
	end
endmodule // nfsb_shift

// >>> design/nfsb_sync.v
`timescale 1ns/1ps
module nfsb_sync #(
	parameter         W   = 1,
	parameter [W-1:0] RST = {W{1'b0}}
) (
	// clock and reset
	input  wire         core_clk,
	input  wire         reset_n,
	// levels
	input  wire [W-1:0] d,
	output reg  [W-1:0] q
);
	reg [W-1:0] meta;

	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			meta <= RST;
			q    <= RST;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule // nfsb_sync
